// ==== count_pkg.sv ====
package count_pkg;
   localparam int CNT_W = 16;
   localparam logic [15:0] CNT_RST = 16'h0000;
   localparam logic [15:0] PRE_RST = 16'h0000;
   localparam logic [15:0] CNT_MAX = 16'h7fff;
   localparam logic [15:0] CNT_MIN = 16'h8000;
   localparam logic [15:0] CNT_NEG1 = 16'hffff;
   localparam logic [15:0] CNT_ZERO = 16'h0000;
   localparam int SYNC_STAGES = 3;
   localparam int CLK_HZ = 20000000;
   localparam int MAX_PULSE_HZ = 10000;
   localparam int MIN_PULSE_CYC = CLK_HZ / MAX_PULSE_HZ;
endpackage : count_pkg

// ==== sync_if.sv ====
`timescale 1ns/1ps
interface sync_if;
   logic pulse_raw;
   logic enable_raw;
   logic pulse_rise;
   logic enable_lvl;
   modport filt (input pulse_raw, input enable_raw, output pulse_rise, output enable_lvl);
   modport core (output pulse_raw, output enable_raw, input pulse_rise, input enable_lvl);
endinterface : sync_if

// ==== input_sync.sv ====
`timescale 1ns/1ps
module input_sync (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // Synchronised pins
   sync_if.filt sif
);
   import count_pkg::*;

   logic [SYNC_STAGES-1:0] pulse_sh_q;
   logic [SYNC_STAGES-1:0] en_sh_q;
   logic pulse_lvl_q;
   logic en_lvl_q;
   wire pulse_agree;
   wire en_agree;

   // Stage 0 feeds only stage 1; stages 1 and 2 must agree
   assign pulse_agree = (pulse_sh_q[1] == pulse_sh_q[2]);
   assign en_agree = (en_sh_q[1] == en_sh_q[2]);
   assign sif.pulse_rise = pulse_agree && pulse_sh_q[2] && !pulse_lvl_q;
   assign sif.enable_lvl = en_lvl_q;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pulse_sh_q <= '0;
         en_sh_q <= '0;
         pulse_lvl_q <= 1'b0;
         en_lvl_q <= 1'b0;
      end else begin
         pulse_sh_q <= {pulse_sh_q[1:0], sif.pulse_raw};
         en_sh_q <= {en_sh_q[1:0], sif.enable_raw};
         if (pulse_agree) pulse_lvl_q <= pulse_sh_q[2];
         if (en_agree) en_lvl_q <= en_sh_q[2];
      end
   end

   property p_one_rise;
      @(posedge ref_clk) disable iff (!nrst)
      sif.pulse_rise |=> !sif.pulse_rise;
   endproperty
   a_one_rise: assert property (p_one_rise)
      else $error("pulse edge reported twice");

   // Pin must have been high at the two samples that the filter compares
   property p_rise_high;
      @(posedge ref_clk) disable iff (!nrst)
      sif.pulse_rise |-> $past(sif.pulse_raw, 2) && $past(sif.pulse_raw, 3);
   endproperty
   a_rise_high: assert property (p_rise_high)
      else $error("edge reported without the pin high");
endmodule : input_sync

// ==== pulse_counter.sv ====
`timescale 1ns/1ps
// Operation
// - While enabled, each counted pulse adds one, starting from last loaded value.
// - Count 7FFF plus one pulse wraps to 8000 and continues upward.
// - Zero-crossing flag rises only on the step from minus one to zero.
// - External mode routes enable pin to gate and drives the zero-cross pin.
// - Preload request copies the preload value into the counter.
// - Counting continues until disabled or reloaded; no stop or saturation.
// - Any signed 16-bit start value is accepted, including 8000.
// - Start value one gives zero crossing after 65535 pulses.
// - Counter, preload value and readable count are sixteen bits.
// - Only rising pulse edges count; falling edges change nothing.
// - Mode clear: software enable gates; mode set: external enable gates.
// - Loading the counter clears the zero-crossing flag.
// - Current count is readable at any time without disturbing counting.
module pulse_counter (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // Pins
   input wire logic pulse_pin,
   input wire logic enable_pin,
   output logic zero_cross_pin,
   // Program control
   input wire logic sw_enable,
   input wire logic ext_mode,
   input wire logic preload_req,
   input wire logic preload_wr,
   input wire logic [count_pkg::CNT_W-1:0] preload_wdata,
   // Program status
   output logic [count_pkg::CNT_W-1:0] preload_value,
   output logic [count_pkg::CNT_W-1:0] count_value,
   output logic zero_cross
);
   import count_pkg::*;

   sync_if sif ();

   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic [CNT_W-1:0] pre_q;
   logic zc_q;
   logic zc_d;
   logic zc_pin_q;
   logic zc_pin_d;
   wire gate;
   wire step;
   wire crossing;
   logic [CNT_W:0] steps_q;
   logic [CNT_W:0] steps_d;
   logic [CNT_W-1:0] start_q;
   logic [CNT_W-1:0] start_d;

   input_sync u_sync (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .sif(sif)
   );

   assign sif.pulse_raw = pulse_pin;
   assign sif.enable_raw = enable_pin;

   assign gate = ext_mode ? sif.enable_lvl : sw_enable;
   assign step = gate && sif.pulse_rise && !preload_req;
   assign crossing = step && (cnt_q == CNT_NEG1);
   // Plain add wraps 7FFF to 8000 with no saturation
   assign cnt_d = preload_req ? pre_q : (step ? cnt_q + 16'h0001 : cnt_q);
   // Load clears the flag; a crossing in that cycle is void since no count happens
   assign zc_d = preload_req ? 1'b0 : (crossing ? 1'b1 : zc_q);
   assign zc_pin_d = ext_mode ? zc_d : 1'b0;
   // Assertion bookkeeping only: start value and steps taken since the last load
   assign start_d = preload_req ? pre_q : start_q;
   assign steps_d = preload_req ? '0 : (step ? steps_q + 17'h0_0001 : steps_q);

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cnt_q <= CNT_RST;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pre_q <= PRE_RST;
      end else if (preload_wr) begin
         pre_q <= preload_wdata;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         zc_q <= 1'b0;
      end else begin
         zc_q <= zc_d;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         zc_pin_q <= 1'b0;
      end else begin
         zc_pin_q <= zc_pin_d;
      end
   end

   // Reset counts as a load of the reset value
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         start_q <= CNT_RST;
         steps_q <= '0;
      end else begin
         start_q <= start_d;
         steps_q <= steps_d;
      end
   end

   assign count_value = cnt_q;
   assign preload_value = pre_q;
   assign zero_cross = zc_q;
   assign zero_cross_pin = zc_pin_q;

   // Datapath: one step per counted edge, plain wrap, load wins
   property p_inc;
      @(posedge ref_clk) disable iff (!nrst)
      step |=> cnt_q == $past(cnt_q) + 16'h0001;
   endproperty
   a_inc: assert property (p_inc)
      else $error("counter did not advance by one");

   property p_wrap;
      @(posedge ref_clk) disable iff (!nrst)
      step && cnt_q == CNT_MAX |=> cnt_q == CNT_MIN;
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("counter did not wrap to 8000");

   property p_load;
      @(posedge ref_clk) disable iff (!nrst)
      preload_req |=> cnt_q == $past(pre_q);
   endproperty
   a_load: assert property (p_load)
      else $error("preload not copied");

   property p_hold;
      @(posedge ref_clk) disable iff (!nrst)
      !gate && !preload_req |=> cnt_q == $past(cnt_q);
   endproperty
   a_hold: assert property (p_hold)
      else $error("count changed while disabled");

   // First crossing after a load needs exactly the span from start value to zero
   property p_cross_count;
      @(posedge ref_clk) disable iff (!nrst)
      crossing && !zc_q |-> steps_q == {1'b0, CNT_NEG1} - {1'b0, start_q};
   endproperty
   a_cross_count: assert property (p_cross_count)
      else $error("zero cross after wrong number of pulses");

   // Flag: set only by the minus one to zero step, cleared only by a load
   property p_zc_set;
      @(posedge ref_clk) disable iff (!nrst)
      $rose(zc_q) |-> $past(cnt_q) == CNT_NEG1 && cnt_q == CNT_ZERO;
   endproperty
   a_zc_set: assert property (p_zc_set)
      else $error("zero cross flag rose at wrong step");

   property p_flag_steady;
      @(posedge ref_clk) disable iff (!nrst)
      !preload_req && cnt_q != CNT_NEG1 |=> zc_q == $past(zc_q);
   endproperty
   a_flag_steady: assert property (p_flag_steady)
      else $error("zero cross flag changed away from a crossing");

   property p_clear;
      @(posedge ref_clk) disable iff (!nrst)
      preload_req |=> !zc_q;
   endproperty
   a_clear: assert property (p_clear)
      else $error("load did not clear zero cross");

   // Gating
   property p_gate;
      @(posedge ref_clk) disable iff (!nrst)
      ext_mode && !sif.enable_lvl && !preload_req |=> cnt_q == $past(cnt_q);
   endproperty
   a_gate: assert property (p_gate)
      else $error("software enable not ignored in external mode");

   property p_sw_gate;
      @(posedge ref_clk) disable iff (!nrst)
      !ext_mode && !sw_enable && !preload_req |=> cnt_q == $past(cnt_q);
   endproperty
   a_sw_gate: assert property (p_sw_gate)
      else $error("count changed with software enable low");

   property p_ext_gate;
      @(posedge ref_clk) disable iff (!nrst)
      ext_mode && sif.enable_lvl && sif.pulse_rise && !preload_req |=> cnt_q == $past(cnt_q) + 16'h0001;
   endproperty
   a_ext_gate: assert property (p_ext_gate)
      else $error("external enable did not gate counting");

   // Zero cross pin
   property p_pin;
      @(posedge ref_clk) disable iff (!nrst)
      !ext_mode |=> !zero_cross_pin;
   endproperty
   a_pin: assert property (p_pin)
      else $error("zero cross pin driven outside external mode");

   property p_pin_follow;
      @(posedge ref_clk) disable iff (!nrst)
      ext_mode |=> zero_cross_pin == zero_cross;
   endproperty
   a_pin_follow: assert property (p_pin_follow)
      else $error("zero cross pin does not follow flag");

   // Preload word
   property p_pre_wr;
      @(posedge ref_clk) disable iff (!nrst)
      preload_wr |=> pre_q == $past(preload_wdata);
   endproperty
   a_pre_wr: assert property (p_pre_wr)
      else $error("preload word not stored");

   property p_pre_keep;
      @(posedge ref_clk) disable iff (!nrst)
      !preload_wr |=> pre_q == $past(pre_q);
   endproperty
   a_pre_keep: assert property (p_pre_keep)
      else $error("preload word changed without a write");
endmodule : pulse_counter

// ==== pulse_src.sv ====
`timescale 1ns/1ps
module pulse_src
   import count_pkg::*;
(
   // Clock
   input wire logic ref_clk,
   // Pins
   output logic pulse_pin,
   output logic enable_pin
);
   initial begin
      pulse_pin = 1'b0;
      enable_pin = 1'b0;
   end
   // Spaced at the maximum pulse rate; faster edges may be lost
   task automatic pulses(input int n);
      for (int i = 0; i < 2 * n; i++) begin
         @(negedge ref_clk) pulse_pin = ~pulse_pin;
         repeat (MIN_PULSE_CYC / 2 - 1) @(negedge ref_clk);
      end
   endtask : pulses
   task automatic set_enable(input logic lvl);
      @(negedge ref_clk) enable_pin = lvl;
   endtask : set_enable
endmodule : pulse_src

// ==== pulse_up_counter_zero_cross_tb.sv ====
`timescale 1ns/1ps
module pulse_up_counter_zero_cross_tb;
   import count_pkg::*;
   logic ref_clk = 1'b0;
   logic nrst;
   logic sw_enable;
   logic ext_mode;
   logic preload_req;
   logic preload_wr;
   logic [15:0] preload_wdata;
   logic pulse_pin, enable_pin, zero_cross_pin, zero_cross;
   logic [15:0] preload_value, count_value;
   int fail_count = 0;
   int check_count = 0;
   always #25 ref_clk = ~ref_clk;
   pulse_src src (.ref_clk(ref_clk), .pulse_pin(pulse_pin), .enable_pin(enable_pin));
   pulse_counter dut (.ref_clk(ref_clk), .nrst(nrst), .pulse_pin(pulse_pin), .enable_pin(enable_pin),
      .zero_cross_pin(zero_cross_pin), .sw_enable(sw_enable), .ext_mode(ext_mode),
      .preload_req(preload_req), .preload_wr(preload_wr), .preload_wdata(preload_wdata),
      .preload_value(preload_value), .count_value(count_value), .zero_cross(zero_cross));
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic state(input logic [15:0] cnt, input logic zc, input logic pin);
      check("count", count_value, cnt);
      check("flag", {15'h0, zero_cross}, {15'h0, zc});
      check("pin", {15'h0, zero_cross_pin}, {15'h0, pin});
   endtask : state
   task automatic load(input logic [15:0] v);
      @(negedge ref_clk) preload_wr = 1'b1;
      preload_wdata = v;
      @(negedge ref_clk) preload_wr = 1'b0;
      preload_req = 1'b1;
      @(negedge ref_clk) preload_req = 1'b0;
      @(negedge ref_clk) check("preload", preload_value, v);
      state(v, 1'b0, 1'b0);
   endtask : load
   task automatic sc_cross;
      sw_enable = 1'b1;
      load(16'hfffe);
      src.pulses(1);
      state(16'hffff, 1'b0, 1'b0);
      src.pulses(1);
      state(CNT_ZERO, 1'b1, 1'b0);
      src.pulses(1);
      state(16'h0001, 1'b1, 1'b0);
      load(16'h7fff);
      src.pulses(1);
      state(CNT_MIN, 1'b0, 1'b0);
   endtask : sc_cross
   task automatic sc_gate;
      sw_enable = 1'b0;
      load(16'h1234);
      src.pulses(1);
      state(16'h1234, 1'b0, 1'b0);
      ext_mode = 1'b1;
      sw_enable = 1'b1;
      src.pulses(1);
      state(16'h1234, 1'b0, 1'b0);
      sw_enable = 1'b0;
      src.set_enable(1'b1);
      load(CNT_NEG1);
      src.pulses(1);
      state(CNT_ZERO, 1'b1, 1'b1);
   endtask : sc_gate
   task automatic sc_reset;
      src.pulses(1);
      state(16'h0001, 1'b1, 1'b1);
      nrst = 1'b0;
      @(negedge ref_clk) check("preload", preload_value, PRE_RST);
      state(CNT_RST, 1'b0, 1'b0);
      nrst = 1'b1;
      src.pulses(1);
      state(16'h0001, 1'b0, 1'b0);
   endtask : sc_reset
   task automatic sc_hold;
      ext_mode = 1'b0;
      sw_enable = 1'b1;
      load(16'hff4c);
      preload_req = 1'b1;
      src.pulses(1);
      state(16'hff4c, 1'b0, 1'b0);
      preload_req = 1'b0;
      src.pulses(1);
      state(16'hff4d, 1'b0, 1'b0);
   endtask : sc_hold
   task automatic results;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : results
   initial begin
      nrst = 1'b0;
      sw_enable = 1'b0;
      ext_mode = 1'b0;
      preload_req = 1'b0;
      preload_wr = 1'b0;
      preload_wdata = 16'h0000;
      repeat (5) @(negedge ref_clk);
      nrst = 1'b1;
      @(negedge ref_clk) check("preload", preload_value, PRE_RST);
      state(CNT_RST, 1'b0, 1'b0);
      sc_cross();
      sc_gate();
      sc_reset();
      sc_hold();
      results();
   end
endmodule : pulse_up_counter_zero_cross_tb
